/* design/adcc_params.svh */
// register map, field positions, reset values and sizes of the conversion control block
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// ****************************************************************
// bus and pin sizes
// ****************************************************************
`define ADCC_ADDR_W        12
`define ADCC_PINS          24
`define ADCC_RES_W         10
`define ADCC_CH_W          5

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ADCC_OFF_CTRL      12'h000
`define ADCC_OFF_CFG       12'h004
`define ADCC_OFF_PINS      12'h008
`define ADCC_OFF_RESULT    12'h00c
`define ADCC_OFF_STATUS    12'h010
`define ADCC_OFF_MASK      12'h014
`define ADCC_OFF_PORTIN    12'h018

// ****************************************************************
// field positions
// ****************************************************************
`define ADCC_CTRL_CONT     5
`define ADCC_CTRL_COCO     7
`define ADCC_CFG_DIV_LSB   0
`define ADCC_CFG_MODE_LSB  2
`define ADCC_CFG_HWEN      4
`define ADCC_MODE_TEN_BIT  2'h2
`define ADCC_CH_OFF        5'h1f
`define ADCC_ST_COCO       0
`define ADCC_ST_MISS       1
`define ADCC_IRQ_W         2

// ****************************************************************
// reset values
// ****************************************************************
`define ADCC_RST_CTRL      8'h1f
`define ADCC_RST_CFG       5'h00
`define ADCC_RST_PINS      24'h00_0000
`define ADCC_RST_MASK      2'h0

`endif

/* design/adcc_pkg.sv */
// types and helpers shared by the conversion control modules
package adcc_pkg;

  typedef enum logic [1:0]
  {
    adcc_st_idle   = 2'b00,
    adcc_st_launch = 2'b01,
    adcc_st_busy   = 2'b10
  } adcc_state_type;

  typedef logic [23:0] adcc_pin_vec_type;
  typedef logic [9:0]  adcc_result_type;

  // cycles between converter clock ticks, minus one, for each divide code
  function automatic logic [2:0] adcc_div_limit(input logic [1:0] code);
    logic [2:0] lim;
    lim = 3'h0;
    unique case (code)
      2'b00: lim = 3'h0;
      2'b01: lim = 3'h1;
      2'b10: lim = 3'h3;
      2'b11: lim = 3'h7;
    endcase
    return lim;
  endfunction : adcc_div_limit

endpackage : adcc_pkg

/* design/adcc_link_if.sv */
// internal carrier between the trigger edge detector, the divider and the controller
`timescale 1ns/10ps
`default_nettype none

interface adcc_link_if;
  logic trig_rise;
  logic conv_tick;
  modport trig_src (output trig_rise);
  modport div_src  (output conv_tick);
  modport ctrl     (input trig_rise, input conv_tick);
endinterface : adcc_link_if

`default_nettype wire

/* design/adcc_trig_edge.sv */
// synchroniser and rising edge detector for the asynchronous hardware trigger
`timescale 1ns/10ps
`default_nettype none

module adcc_trig_edge
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // asynchronous trigger pin
  input  wire logic       hw_trigger_input,
  // edge towards the controller
  adcc_link_if.trig_src   link
);

  logic sync0_q;
  logic sync1_q;
  logic prev_q;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync0_q <= 1'b0;
      sync1_q <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      sync0_q <= hw_trigger_input;
      sync1_q <= sync0_q;
      prev_q  <= sync1_q;
    end
  end

  assign link.trig_rise = sync1_q & ~prev_q;

endmodule : adcc_trig_edge

`default_nettype wire

/* design/adcc_clk_div.sv */
// converter clock divider: one tick every 1, 2, 4 or 8 bus clocks
`timescale 1ns/10ps
`default_nettype none

module adcc_clk_div
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // divide code
  input  wire logic [1:0] conv_clock_divide,
  // tick towards the controller
  adcc_link_if.div_src    link
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       tick_q;
  logic       tick_d;
  logic [2:0] lim;

  // compare with >= so a smaller ratio written mid-count cannot strand the counter
  always_comb
  begin
    lim    = adcc_pkg::adcc_div_limit(conv_clock_divide);
    tick_d = (cnt_q >= lim);
    cnt_d  = tick_d ? 3'h0 : 3'(cnt_q + 3'h1);
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q  <= 3'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign link.conv_tick = tick_q;

endmodule : adcc_clk_div

`default_nettype wire

/* design/adcc_ctrl.sv */
// conversion control top: apb registers, trigger sequencing, analog pin gating, interrupt
`timescale 1ns/10ps
`default_nettype none
`include "adcc_params.svh"

module adcc_ctrl
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`ADCC_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // interrupt
  output logic                            irq,
  // converter core
  input  wire logic                       hw_trigger_input,
  input  wire logic                       conv_done,
  input  wire logic [`ADCC_RES_W-1:0]     conv_result,
  output logic                            conv_clk_tick,
  output logic                            conv_start,
  output logic                            conv_abort,
  output logic [`ADCC_CH_W-1:0]           input_channel_select,
  output logic                            conv_ten_bit,
  // port logic and pads
  input  wire logic [`ADCC_PINS-1:0]      port_out_data,
  input  wire logic [`ADCC_PINS-1:0]      port_out_en,
  input  wire logic [`ADCC_PINS-1:0]      port_pullup_req,
  input  wire logic [`ADCC_PINS-1:0]      pad_in,
  output logic [`ADCC_PINS-1:0]           pad_out,
  output logic [`ADCC_PINS-1:0]           pad_oe_b,
  output logic [`ADCC_PINS-1:0]           pad_pullup_en,
  output logic [`ADCC_PINS-1:0]           port_read_data
);

  // ****************************************************************
  // submodules
  // ****************************************************************
  adcc_link_if u_link ();

  logic [7:0]                         ctrl_q;
  logic [7:0]                         ctrl_d;
  logic [4:0]                         cfg_q;
  logic [4:0]                         cfg_d;

  adcc_trig_edge u_trig
  (
    .clock            (clock),
    .rst_b            (rst_b),
    .hw_trigger_input (hw_trigger_input),
    .link             (u_link.trig_src)
  );

  adcc_clk_div u_div
  (
    .clock             (clock),
    .rst_b             (rst_b),
    .conv_clock_divide (cfg_q[`ADCC_CFG_DIV_LSB +: 2]),
    .link              (u_link.div_src)
  );

  // ****************************************************************
  // apb access decode
  // ****************************************************************
  logic                               pready_q;
  logic                               pready_d;
  logic [31:0]                        prdata_q;
  logic [31:0]                        prdata_d;
  logic                               pslverr_q;
  logic                               pslverr_d;
  logic                               acc;
  logic                               wr;
  logic                               ctrl_wr;
  logic                               mapped;
  logic [`ADCC_CH_W-1:0]              new_ch;
  logic                               hw_en;
  logic                               trig_rise;

  // one wait state: the answer is registered on the same edge that raises pready
  assign acc       = psel & penable & pready_q;
  assign wr        = acc & pwrite & mapped;
  assign ctrl_wr   = wr & (paddr == `ADCC_OFF_CTRL);
  assign new_ch    = pwdata[`ADCC_CH_W-1:0];
  assign hw_en     = cfg_q[`ADCC_CFG_HWEN];
  assign trig_rise = u_link.trig_rise;

  always_comb
  begin
    unique case (paddr)
      `ADCC_OFF_CTRL, `ADCC_OFF_CFG, `ADCC_OFF_PINS, `ADCC_OFF_RESULT,
      `ADCC_OFF_STATUS, `ADCC_OFF_MASK, `ADCC_OFF_PORTIN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [`ADCC_PINS-1:0]              apc_q;
  logic [`ADCC_PINS-1:0]              apc_d;
  logic [`ADCC_IRQ_W-1:0]             mask_q;
  logic [`ADCC_IRQ_W-1:0]             mask_d;

  always_comb
  begin
    ctrl_d = ctrl_q;
    cfg_d  = cfg_q;
    apc_d  = apc_q;
    mask_d = mask_q;
    if (ctrl_wr)
      ctrl_d = {1'b0, 1'b0, pwdata[`ADCC_CTRL_CONT], new_ch};
    if (wr && paddr == `ADCC_OFF_CFG)
      cfg_d = pwdata[4:0];
    if (wr && paddr == `ADCC_OFF_PINS)
      apc_d = pwdata[`ADCC_PINS-1:0];
    if (wr && paddr == `ADCC_OFF_MASK)
      mask_d = pwdata[`ADCC_IRQ_W-1:0];
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= `ADCC_RST_CTRL;
      cfg_q  <= `ADCC_RST_CFG;
      apc_q  <= `ADCC_RST_PINS;
      mask_q <= `ADCC_RST_MASK;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cfg_q  <= cfg_d;
      apc_q  <= apc_d;
      mask_q <= mask_d;
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  adcc_pkg::adcc_state_type           state_q;
  adcc_pkg::adcc_state_type           state_d;
  logic                               cont_q;
  logic                               cont_d;
  logic                               start_q;
  logic                               start_d;
  logic                               abort_q;
  logic                               abort_d;
  logic                               ten_q;
  logic                               ten_d;
  adcc_pkg::adcc_result_type          result_q;
  adcc_pkg::adcc_result_type          result_d;
  logic [`ADCC_IRQ_W-1:0]             set_ev;
  logic                               mode_ten;

  assign mode_ten = (cfg_q[`ADCC_CFG_MODE_LSB +: 2] == `ADCC_MODE_TEN_BIT);

  always_comb
  begin
    state_d  = state_q;
    cont_d   = cont_q;
    start_d  = 1'b0;
    abort_d  = 1'b0;
    ten_d    = ten_q;
    result_d = result_q;
    set_ev   = '0;
    if (ctrl_wr)
    begin
      abort_d = (state_q != adcc_pkg::adcc_st_idle);
      cont_d  = 1'b0;
      state_d = adcc_pkg::adcc_st_idle;
      // in hardware mode the write only arms; the next trigger edge starts
      if (new_ch != `ADCC_CH_OFF && !hw_en)
      begin
        state_d = adcc_pkg::adcc_st_launch;
        start_d = 1'b1;
        cont_d  = pwdata[`ADCC_CTRL_CONT];
        ten_d   = mode_ten;
      end
    end
    else
    begin
      unique case (state_q)
        adcc_pkg::adcc_st_idle:
          if (hw_en && trig_rise && ctrl_q[`ADCC_CH_W-1:0] != `ADCC_CH_OFF)
          begin
            state_d = adcc_pkg::adcc_st_launch;
            start_d = 1'b1;
            cont_d  = ctrl_q[`ADCC_CTRL_CONT];
            ten_d   = mode_ten;
          end
        adcc_pkg::adcc_st_launch:
          state_d = adcc_pkg::adcc_st_busy;
        adcc_pkg::adcc_st_busy:
          if (conv_done)
          begin
            result_d = ten_q ? conv_result : {2'h0, conv_result[7:0]};
            set_ev[`ADCC_ST_COCO] = 1'b1;
            if (cont_q)
            begin
              state_d = adcc_pkg::adcc_st_launch;
              start_d = 1'b1;
              ten_d   = mode_ten;
            end
            else
              state_d = adcc_pkg::adcc_st_idle;
          end
        default:
          state_d = adcc_pkg::adcc_st_idle;
      endcase
      // edges during a conversion or a running sequence are dropped, only noted
      if (hw_en && trig_rise && state_q != adcc_pkg::adcc_st_idle)
        set_ev[`ADCC_ST_MISS] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q  <= adcc_pkg::adcc_st_idle;
      cont_q   <= 1'b0;
      start_q  <= 1'b0;
      abort_q  <= 1'b0;
      ten_q    <= 1'b0;
      result_q <= '0;
    end
    else
    begin
      state_q  <= state_d;
      cont_q   <= cont_d;
      start_q  <= start_d;
      abort_q  <= abort_d;
      ten_q    <= ten_d;
      result_q <= result_d;
    end
  end

  // ****************************************************************
  // interrupt status, mask and apb answer
  // ****************************************************************
  logic [`ADCC_IRQ_W-1:0]             status_q;
  logic [`ADCC_IRQ_W-1:0]             status_d;
  logic                               irq_q;
  logic                               irq_d;

  always_comb
  begin
    status_d = status_q;
    if (wr && paddr == `ADCC_OFF_STATUS)
      status_d = status_q & ~pwdata[`ADCC_IRQ_W-1:0];
    // a new event in the clearing cycle survives the clear
    status_d = status_d | set_ev;
    irq_d    = |(status_d & mask_d);
  end

  always_comb
  begin
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~mapped;
    prdata_d  = '0;
    if (pready_d && !pwrite)
    begin
      unique case (paddr)
        `ADCC_OFF_CTRL:   prdata_d = {24'h0, status_q[`ADCC_ST_COCO], ctrl_q[6:0]};
        `ADCC_OFF_CFG:    prdata_d = {27'h0, cfg_q};
        `ADCC_OFF_PINS:   prdata_d = {8'h0, apc_q};
        `ADCC_OFF_RESULT: prdata_d = {22'h0, result_q};
        `ADCC_OFF_STATUS: prdata_d = {30'h0, status_q};
        `ADCC_OFF_MASK:   prdata_d = {30'h0, mask_q};
        `ADCC_OFF_PORTIN: prdata_d = {8'h0, port_read_data};
        default:          prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_q  <= '0;
      irq_q     <= 1'b0;
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      status_q  <= status_d;
      irq_q     <= irq_d;
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************************************
  // analog pin gating of the port logic
  // ****************************************************************
  logic [`ADCC_PINS-1:0]              pin_s0_q;
  logic [`ADCC_PINS-1:0]              pin_s1_q;
  logic [`ADCC_PINS-1:0]              pad_out_q;
  logic [`ADCC_PINS-1:0]              pad_oe_b_q;
  logic [`ADCC_PINS-1:0]              pull_q;
  logic [`ADCC_PINS-1:0]              port_rd_q;
  logic [`ADCC_PINS-1:0]              pad_oe_b_d;
  logic [`ADCC_PINS-1:0]              pull_d;
  logic [`ADCC_PINS-1:0]              port_rd_d;

  always_comb
  begin
    pad_oe_b_d = ~(port_out_en & ~apc_q);
    port_rd_d  = pin_s1_q & ~apc_q;
    pull_d     = port_pullup_req & ~apc_q;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s0_q   <= '0;
      pin_s1_q   <= '0;
      pad_out_q  <= '0;
      pad_oe_b_q <= '1;
      pull_q     <= '0;
      port_rd_q  <= '0;
    end
    else
    begin
      pin_s0_q   <= pad_in;
      pin_s1_q   <= pin_s0_q;
      pad_out_q  <= port_out_data;
      pad_oe_b_q <= pad_oe_b_d;
      pull_q     <= pull_d;
      port_rd_q  <= port_rd_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pready               = pready_q;
  assign prdata               = prdata_q;
  assign pslverr              = pslverr_q;
  assign irq                  = irq_q;
  assign conv_clk_tick        = u_link.conv_tick;
  assign conv_start           = start_q;
  assign conv_abort           = abort_q;
  assign input_channel_select = ctrl_q[`ADCC_CH_W-1:0];
  assign conv_ten_bit         = ten_q;
  assign pad_out              = pad_out_q;
  assign pad_oe_b             = pad_oe_b_q;
  assign pad_pullup_en        = pull_q;
  assign port_read_data       = port_rd_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic [3:0] gap_q;
  logic [3:0] same_q;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_q  <= 4'h0;
      same_q <= 4'h0;
    end
    else
    begin
      gap_q  <= conv_clk_tick ? 4'h0 : ((gap_q == 4'hf) ? gap_q : 4'(gap_q + 4'h1));
      same_q <= (cfg_d[1:0] != cfg_q[1:0]) ? 4'h0 :
                ((same_q == 4'hf) ? same_q : 4'(same_q + 4'h1));
    end
  end

  property p_div_ratio;
    (conv_clk_tick && same_q > 4'h9) |-> (gap_q == {1'b0, adcc_pkg::adcc_div_limit(cfg_q[1:0])});
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("tick spacing off ratio");

  property p_pad_hiz;
    (apc_q != '0) |=> ((pad_oe_b & $past(apc_q)) == $past(apc_q));
  endproperty
  a_pad_hiz: assert property (p_pad_hiz) else $error("analog pin still driven");

  property p_port_zero;
    ##1 ((port_read_data & $past(apc_q)) == '0);
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("analog pin read not zero");

  property p_pull_off;
    ##1 ((pad_pullup_en & $past(apc_q)) == '0);
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("analog pin pullup on");

  // a control rewrite in the launch cycle legally sends the sequencer back to idle or to a new launch
  sequence s_launch;
    (conv_start && state_q == adcc_pkg::adcc_st_launch)
      ##1 (state_q == adcc_pkg::adcc_st_busy || $past(ctrl_wr));
  endsequence

  property p_hw_start;
    (state_q == adcc_pkg::adcc_st_idle && hw_en && trig_rise && !ctrl_wr
      && input_channel_select != `ADCC_CH_OFF) |=> s_launch;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("trigger edge did not start");

  property p_edge_ignored;
    (state_q == adcc_pkg::adcc_st_busy && trig_rise && !conv_done && !ctrl_wr)
      |=> !conv_start ##1 status_q[`ADCC_ST_MISS];
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("busy edge acted");

  property p_cont_hold;
    (cont_q && !ctrl_wr && state_q == adcc_pkg::adcc_st_busy && conv_done)
      |=> s_launch;
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("continuous did not restart");

  property p_sw_start;
    (ctrl_wr && !hw_en && new_ch != `ADCC_CH_OFF) |=> s_launch;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("control write did not start");

  property p_off_idle;
    (ctrl_wr && new_ch == `ADCC_CH_OFF)
      |=> (state_q == adcc_pkg::adcc_st_idle && !cont_q && !conv_start)[*2];
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("channel off did not idle");

  property p_abort;
    (ctrl_wr && state_q == adcc_pkg::adcc_st_busy) |=> conv_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("rewrite did not abort");

  property p_result;
    (state_q == adcc_pkg::adcc_st_busy && conv_done && !ctrl_wr)
      |=> status_q[`ADCC_ST_COCO] && result_q[7:0] == $past(conv_result[7:0])
          && (ten_q || $past(ten_q) || result_q[9:8] == 2'h0);
  endproperty
  a_result: assert property (p_result) else $error("result or flag wrong");

endmodule : adcc_ctrl

`default_nettype wire

/* tb/adcc_core_model.sv */
// behavioural analog converter core driven by the control block
`timescale 1ns/10ps
`default_nettype none

module adcc_core_model
#(
  parameter int TICKS = 4
)
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // control side
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [9:0] sample_val,
  // result side
  output logic            done,
  output logic [9:0]      result
);
  int   cnt_q;
  logic busy_q;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 0;
      done   <= 1'b0;
      result <= 10'h000;
    end
    else
    begin
      done   <= 1'b0;
      // bus is not held after done: toggle so stale data never looks valid
      result <= ~result;
      if (start)
      begin
        busy_q <= 1'b1;
        cnt_q  <= 0;
      end
      else if (abort)
        busy_q <= 1'b0;
      else if (busy_q && tick)
      begin
        cnt_q <= cnt_q + 1;
        if (cnt_q == TICKS - 1)
        begin
          busy_q <= 1'b0;
          done   <= 1'b1;
          result <= sample_val;
        end
      end
    end
  end
endmodule : adcc_core_model

`default_nettype wire

/* tb/testbench.sv */
// self-checking bench of the conversion control block
`timescale 1ns/10ps
`default_nettype none
`include "adcc_params.svh"

module testbench;
  logic clock = 1'b0, rst_b = 1'b0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, trig = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'h0000d4ed;
  logic done, tick, start, abort, ten, tbit;
  logic [9:0] res, sval = 10'h000, exp_res;
  logic [23:0] po = 0, pe = 0, pu = 0, pin = 0, pout, oe_b, pull, prd;
  logic [4:0] ch;
  int error_cnt = 0, samples_checked = 0, starts = 0, st0, n, aborts = 0;

  always #50 clock = ~clock;

  adcc_ctrl i_adcc_ctrl (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq), .hw_trigger_input(trig), .conv_done(done),
    .conv_result(res), .conv_clk_tick(tick), .conv_start(start), .conv_abort(abort),
    .input_channel_select(ch), .conv_ten_bit(tbit), .port_out_data(po), .port_out_en(pe),
    .port_pullup_req(pu), .pad_in(pin), .pad_out(pout), .pad_oe_b(oe_b),
    .pad_pullup_en(pull), .port_read_data(prd));

  adcc_core_model i_adcc_core_model (.clock(clock), .rst_b(rst_b), .tick(tick),
    .start(start), .abort(abort), .sample_val(sval), .done(done), .result(res));

  // expected result follows the resolution the bench selected
  always @(posedge clock)
  begin
    if (start === 1'b1)
      starts++;
    if (abort === 1'b1)
      aborts++;
    if (done === 1'b1)
      exp_res = ten ? res : {2'h0, res[7:0]};
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = pslverr ? 32'hbad0 : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic pulse();
    trig <= 1'b1;
    repeat (4) @(posedge clock);
    trig <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulse

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    apb(0, `ADCC_OFF_CTRL, 0);
    chk(rd, 32'h1f);
    apb(0, `ADCC_OFF_CFG, 0);
    chk(rd, 32'h0);
    apb(0, 12'h01c, 0);
    chk(rd, 32'hbad0);
    for (int c = 0; c < 4; c++)
    begin
      apb(1, `ADCC_OFF_CFG, c);
      n = 0;
      repeat (16)
      begin
        @(posedge clock);
        n += tick;
      end
      chk(n, 16 >> c);
    end
    r = xs();
    apb(1, `ADCC_OFF_PINS, r[23:0]);
    pin <= xs();
    po <= '1;
    pe <= '1;
    pu <= '1;
    repeat (5) @(posedge clock);
    chk(oe_b, r[23:0]);
    chk(pull, {8'h0, ~r[23:0]});
    chk(pout, 32'h00ff_ffff);
    chk(prd, pin & ~r[23:0]);
    apb(0, `ADCC_OFF_PORTIN, 0);
    chk(rd, {8'h0, pin & ~r[23:0]});
    apb(1, `ADCC_OFF_MASK, 1);
    for (int m = 0; m < 3; m += 2)
    begin
      ten = (m == 2);
      apb(1, `ADCC_OFF_CFG, m << 2);
      sval <= xs();
      apb(1, `ADCC_OFF_CTRL, 3);
      chk(ch, 32'h3);
      while (irq !== 1'b1) @(posedge clock);
      chk(tbit, ten);
      apb(0, `ADCC_OFF_RESULT, 0);
      chk(rd, exp_res);
      apb(0, `ADCC_OFF_STATUS, 0);
      chk(rd, 32'h1);
      apb(1, `ADCC_OFF_STATUS, 1);
      chk(irq, 1'b0);
    end
    st0 = starts;
    apb(1, `ADCC_OFF_CTRL, 32'h3f);
    repeat (30) @(posedge clock);
    chk(starts, st0);
    apb(1, `ADCC_OFF_CTRL, 32'h23);
    repeat (60) @(posedge clock);
    chk(starts - st0 > 3, 1);
    apb(1, `ADCC_OFF_CTRL, 32'h1f);
    st0 = starts;
    repeat (30) @(posedge clock);
    chk(starts, st0);
    chk(aborts > 0, 1);
    // slowest ratio keeps the conversion running while the second edge arrives
    apb(1, `ADCC_OFF_CFG, 32'h1b);
    apb(1, `ADCC_OFF_STATUS, 3);
    apb(1, `ADCC_OFF_CTRL, 3);
    repeat (10) @(posedge clock);
    chk(starts, st0);
    pulse();
    pulse();
    repeat (30) @(posedge clock);
    chk(starts - st0, 1);
    apb(0, `ADCC_OFF_STATUS, 0);
    chk(rd, 32'h3);
    apb(1, `ADCC_OFF_STATUS, 3);
    apb(1, `ADCC_OFF_CFG, 32'h18);
    apb(1, `ADCC_OFF_CTRL, 32'h23);
    st0 = starts;
    pulse();
    pulse();
    repeat (60) @(posedge clock);
    chk(starts - st0 > 3, 1);
    apb(0, `ADCC_OFF_STATUS, 0);
    chk(rd[1], 1'b1);
    apb(1, `ADCC_OFF_CTRL, 32'h1f);
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    results();
  end
endmodule : testbench

`default_nettype wire
